/* File: hw/dsadc_map.svh */
/*
  Constants of the dual-slope converter sequencer: offsets, fields, resets, counts.
  Assumes it is included by bare name after the package.
*/
`ifndef DSADC_MAP_SVH
`define DSADC_MAP_SVH
`define DSADC_CTRL_OFS 12'h000
`define DSADC_RESULT_OFS 12'h004
`define DSADC_STAT_OFS 12'h008
`define DSADC_CTRL_RUN 0
`define DSADC_CTRL_MODE 1
`define DSADC_CTRL_RST 2'h1
`define DSADC_INT_CYC 13'h0800
`define DSADC_FULL_CYC 13'h1000
`define DSADC_AZ_MIN_CYC 13'h0800
`define DSADC_START_DLY 13'h0007
`endif

/* File: hw/dsadc_pkg.sv */
/*
  Types of the dual-slope converter sequencer.
  Assumes nothing of its surroundings.
*/
package dsadc_pkg;
  typedef enum logic [4:0] {
    ST_AZ = 5'h01, ST_HOLD = 5'h02, ST_DLY = 5'h04, ST_INT = 5'h08, ST_DEI = 5'h10
  } dsadc_phase_type;
  typedef enum logic [5:0] {
    HS_IDLE = 6'h01, HS_HWAIT = 6'h02, HS_HLOAD = 6'h04,
    HS_LWAIT = 6'h08, HS_LLOAD = 6'h10, HS_FWAIT = 6'h20
  } dsadc_hs_type;
  typedef struct packed {
    logic over_range;
    logic sign_flag;
    logic [11:0] count;
  } dsadc_result_type;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dsadc_apb_req_type;
endpackage : dsadc_pkg

/* File: hw/dsadc_top.sv */
/*
  Sequencer of a 12-bit dual-slope converter with latches, byte drivers and APB.
  Assumes comparator, sign and send pins are asynchronous; APB shares i_clock.
*/
`timescale 1ns/1ps
`include "dsadc_map.svh"
module dsadc_top
  import dsadc_pkg::*;
#(
  parameter logic [12:0] AZ_MIN = `DSADC_AZ_MIN_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // APB slave
  input wire dsadc_apb_req_type i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Analog front end
  input wire logic i_zero_cross,
  input wire logic i_sign,
  output logic [4:0] o_phase,
  output logic o_status,
  // Handshake ready from receiver
  input wire logic i_send,
  // Enable pins, two-way
  input wire logic i_chip_enable_n,
  input wire logic i_low_byte_enable_n,
  input wire logic i_high_byte_enable_n,
  output logic o_chip_enable_n,
  output logic o_low_byte_enable_n,
  output logic o_high_byte_enable_n,
  output logic o_enables_oe,
  // Byte drivers
  output logic [7:0] o_low_data,
  output logic o_low_oe,
  output logic [5:0] o_high_data,
  output logic o_high_oe
);
  dsadc_phase_type state_ff, nxt_state;
  dsadc_hs_type hs_ff, nxt_hs;
  dsadc_result_type result_ff;
  logic [12:0] pc_ff;
  logic [5:0] s1_ff, s2_ff;
  logic [1:0] ctrl_ff;
  logic crossed_ff, sign_ff, status_ff, latch_q_ff, mode_q_ff, pend_ff;
  logic zc, cross_now, full_now, latch_fire, run, mode, hs_start, access;
  logic ce_s, lb_s, hb_s, send_s;

  // Register select: 0 ctrl, 1 result, 2 status, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    unique case (a)
      `DSADC_CTRL_OFS: reg_sel = 2'h0;
      `DSADC_RESULT_OFS: reg_sel = 2'h1;
      `DSADC_STAT_OFS: reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction : reg_sel

  // Two-stage synchronisers, enables idle high
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_ff <= 6'h38;
      s2_ff <= 6'h38;
    end else begin
      s1_ff <= {i_chip_enable_n, i_low_byte_enable_n, i_high_byte_enable_n,
                i_send, i_sign, i_zero_cross};
      s2_ff <= s1_ff;
    end
  end
  assign zc = s2_ff[0];
  assign send_s = s2_ff[2];
  assign hb_s = s2_ff[3];
  assign lb_s = s2_ff[4];
  assign ce_s = s2_ff[5];
  assign run = ctrl_ff[`DSADC_CTRL_RUN];
  assign mode = ctrl_ff[`DSADC_CTRL_MODE];

  // Conversion events
  assign cross_now = (state_ff == ST_DEI) && zc && !crossed_ff;
  assign full_now = (state_ff == ST_DEI) && (pc_ff == `DSADC_FULL_CYC - 13'h0001);
  assign latch_fire = cross_now || (full_now && !crossed_ff);

  // Phase sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_AZ: if (pc_ff == AZ_MIN - 13'h0001) begin
        nxt_state = run ? ST_INT : ST_HOLD;
      end
      ST_HOLD: if (run) begin
        nxt_state = ST_DLY;
      end
      ST_DLY: if (pc_ff == `DSADC_START_DLY - 13'h0002) begin
        nxt_state = ST_INT;
      end
      ST_INT: if (pc_ff == `DSADC_INT_CYC - 13'h0001) begin
        nxt_state = ST_DEI;
      end
      ST_DEI: if (full_now || (!run && (crossed_ff || cross_now))) begin
        nxt_state = ST_AZ;
      end
    endcase
  end

  // Phase state and period counter
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_AZ;
      pc_ff <= 13'h0000;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= (nxt_state != state_ff) ? 13'h0000 : pc_ff + 13'h0001;
    end
  end

  // Sign capture and crossing flag
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sign_ff <= 1'b0;
      crossed_ff <= 1'b0;
    end else begin
      if (state_ff == ST_INT && nxt_state == ST_DEI) begin
        sign_ff <= s2_ff[1];
      end
      crossed_ff <= (state_ff == ST_DEI) && (crossed_ff || cross_now);
    end
  end

  // Output latches, frozen during handshake
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_ff <= '0;
    end else if (latch_fire && hs_ff == HS_IDLE) begin
      result_ff.count <= cross_now ? pc_ff[11:0] : 12'hFFF;
      result_ff.sign_flag <= sign_ff;
      result_ff.over_range <= !cross_now;
    end
  end

  // Status: up at integrate, down after the latch write
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_ff <= 1'b0;
      latch_q_ff <= 1'b0;
    end else begin
      latch_q_ff <= latch_fire;
      if (nxt_state == ST_INT && state_ff != ST_INT) begin
        status_ff <= 1'b1;
      end else if (latch_q_ff) begin
        status_ff <= 1'b0;
      end
    end
  end

  // Handshake entry: mode edge or mode high after a latch
  assign hs_start = (hs_ff == HS_IDLE) && !latch_fire &&
                    (pend_ff || (latch_q_ff && mode));
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_q_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      mode_q_ff <= mode;
      if (hs_start || hs_ff != HS_IDLE) begin
        pend_ff <= 1'b0;
      end else if (mode && !mode_q_ff) begin
        pend_ff <= 1'b1;
      end
    end
  end

  // Handshake byte sequence, high byte first
  always_comb begin
    nxt_hs = hs_ff;
    unique case (hs_ff)
      HS_IDLE: if (hs_start) nxt_hs = HS_HWAIT;
      HS_HWAIT: if (send_s) nxt_hs = HS_HLOAD;
      HS_HLOAD: nxt_hs = HS_LWAIT;
      HS_LWAIT: if (send_s) nxt_hs = HS_LLOAD;
      HS_LLOAD: nxt_hs = HS_FWAIT;
      HS_FWAIT: if (send_s) nxt_hs = HS_IDLE;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hs_ff <= HS_IDLE;
    end else begin
      hs_ff <= nxt_hs;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_chip_enable_n <= 1'b1;
      o_low_byte_enable_n <= 1'b1;
      o_high_byte_enable_n <= 1'b1;
      o_enables_oe <= 1'b0;
      o_low_oe <= 1'b0;
      o_high_oe <= 1'b0;
      o_low_data <= 8'h00;
      o_high_data <= 6'h00;
    end else begin
      o_chip_enable_n <= !(nxt_hs == HS_HLOAD || nxt_hs == HS_LLOAD);
      o_high_byte_enable_n <= !(nxt_hs == HS_HLOAD || nxt_hs == HS_LWAIT);
      o_low_byte_enable_n <= !(nxt_hs == HS_LLOAD || nxt_hs == HS_FWAIT);
      o_enables_oe <= mode || nxt_hs != HS_IDLE;
      if (nxt_hs == HS_IDLE && !mode) begin
        o_low_oe <= !ce_s && !lb_s;
        o_high_oe <= !ce_s && !hb_s;
      end else begin
        o_low_oe <= nxt_hs == HS_LLOAD || nxt_hs == HS_FWAIT;
        o_high_oe <= nxt_hs == HS_HLOAD || nxt_hs == HS_LWAIT;
      end
      o_low_data <= result_ff.count[7:0];
      o_high_data <= {result_ff.over_range, result_ff.sign_flag, result_ff.count[11:8]};
    end
  end
  assign o_phase = state_ff;
  assign o_status = status_ff;

  // APB slave, ready in the second access cycle
  assign access = i_apb.psel && i_apb.penable;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= access && !o_pready;
      o_pslverr <= access && !o_pready && reg_sel(i_apb.paddr) == 2'h3;
      o_prdata <= 32'h0000_0000;
      if (access && !o_pready && !i_apb.pwrite) begin
        unique case (reg_sel(i_apb.paddr))
          2'h0: o_prdata <= {30'h0000_0000, ctrl_ff};
          2'h1: o_prdata <= {18'h00000, result_ff};
          2'h2: o_prdata <= {30'h0000_0000, hs_ff != HS_IDLE, status_ff};
          2'h3: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register: run and mode
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_ff <= `DSADC_CTRL_RST;
    end else if (access && o_pready && i_apb.pwrite && reg_sel(i_apb.paddr) == 2'h0) begin
      ctrl_ff <= i_apb.pwdata[1:0];
    end
  end

  // Checks
  a_status_rise: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(status_ff) |-> state_ff == ST_INT && $past(state_ff) != ST_INT)
    else $error("status rose outside integrate start");
  a_status_fall: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    latch_fire |=> status_ff ##1 !status_ff)
    else $error("status did not fall after latch");
  a_latch_frozen: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !status_ff |=> $stable(result_ff))
    else $error("latch changed while status low");
  a_start_delay: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_HOLD && run |-> ##7 (state_ff == ST_INT && status_ff))
    else $error("integrate not seven periods after run");
  a_hold_wait: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_HOLD && !run |=> state_ff == ST_HOLD)
    else $error("left hold while run low");
  a_short_cycle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_DEI && crossed_ff && !run |=> state_ff == ST_AZ)
    else $error("deintegrate not cut short");
  a_hs_no_update: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    hs_ff != HS_IDLE |=> $stable(result_ff))
    else $error("latch updated during handshake");
  a_mode_drive: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    mode |=> o_enables_oe)
    else $error("enable pins not driven with mode high");
  a_az_minimum: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_AZ && nxt_state != ST_AZ |-> pc_ff == AZ_MIN - 13'h0001)
    else $error("auto-zero shorter than minimum");
  a_int_length: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_ff == ST_INT && nxt_state == ST_DEI |-> pc_ff == `DSADC_INT_CYC - 13'h0001)
    else $error("integrate length wrong");
  a_over_range: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    latch_fire && hs_ff == HS_IDLE && !cross_now |=> result_ff.over_range)
    else $error("over-range not set at full scale");
endmodule : dsadc_top

/* File: verification/dsadc_host_model.sv */
/*
  Host bus model that reads result bytes through the chip and byte enables.
  Assumes the bench resolves the enable wires and feeds the byte drivers in.
*/
`timescale 1ns/1ps
module dsadc_host_model (
  // Clock and converter status
  input wire logic i_clock,
  input wire logic i_status,
  // Byte drivers of the converter
  input wire logic [7:0] i_low_data,
  input wire logic i_low_oe,
  input wire logic [5:0] i_high_data,
  input wire logic i_high_oe,
  // Enables driven by the host, idle high
  output logic o_chip_enable_n,
  output logic o_low_byte_enable_n,
  output logic o_high_byte_enable_n
);
  logic [7:0] last_byte = 8'h00;
  // Released enables sit at their pulled-up level
  initial begin
    o_chip_enable_n = 1'b1;
    o_low_byte_enable_n = 1'b1;
    o_high_byte_enable_n = 1'b1;
  end
  // One byte read; bit 8 says the driver was on, a dead bus reads inverted
  task automatic read_byte(input bit hi, input bit sel, input int hold, output logic [8:0] b);
    int n;
    n = 0;
    while (i_status !== 1'b0 && n < 9000) begin
      @(posedge i_clock);
      n++;
    end
    o_chip_enable_n <= !sel;
    o_high_byte_enable_n <= !hi;
    o_low_byte_enable_n <= hi;
    repeat (hold) @(posedge i_clock);
    if ((hi ? i_high_oe : i_low_oe) === 1'b1) begin
      b = {1'b1, hi ? {2'b00, i_high_data} : i_low_data};
    end else begin
      b = {1'b0, ~last_byte};
    end
    last_byte = b[7:0];
    o_chip_enable_n <= 1'b1;
    o_high_byte_enable_n <= 1'b1;
    o_low_byte_enable_n <= 1'b1;
    @(posedge i_clock);
  endtask : read_byte
endmodule : dsadc_host_model

/* File: verification/dsadc_tb_top.sv */
/*
  Bench of the converter sequencer: APB master, front-end stimulus, host reads, model.
  Assumes the design, its header and the host model are compiled before it.
*/
`timescale 1ns/1ps
`include "dsadc_map.svh"
module dual_slope_adc_sequencer_direct_port_tb_top;
  import dsadc_pkg::*;
  logic i_clock, i_rst_b, i_zero_cross, i_sign, i_send;
  dsadc_apb_req_type apb;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_status, o_enables_oe, o_low_oe, o_high_oe;
  logic o_chip_enable_n, o_low_byte_enable_n, o_high_byte_enable_n;
  logic host_ce_n, host_lbe_n, host_hbe_n;
  logic [4:0] o_phase;
  logic [7:0] o_low_data;
  logic [5:0] o_high_data;
  logic [31:0] rd;
  logic [8:0] b;
  logic er;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int k_cur = 5000;
  int dcnt = 0;
  int prev_t = -1;
  int n;
  bit s_cur = 1'b0;
  dsadc_result_type exp_r;
  dsadc_result_type exp_q[$];
  // Enable wires: device drives when its enable is up, else the host
  wire logic ce_w = o_enables_oe ? o_chip_enable_n : host_ce_n;
  wire logic lbe_w = o_enables_oe ? o_low_byte_enable_n : host_lbe_n;
  wire logic hbe_w = o_enables_oe ? o_high_byte_enable_n : host_hbe_n;
  dsadc_top dsadc_top_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_apb(apb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_zero_cross(i_zero_cross), .i_sign(i_sign), .o_phase(o_phase), .o_status(o_status),
    .i_send(i_send), .i_chip_enable_n(ce_w), .i_low_byte_enable_n(lbe_w),
    .i_high_byte_enable_n(hbe_w), .o_chip_enable_n(o_chip_enable_n),
    .o_low_byte_enable_n(o_low_byte_enable_n), .o_high_byte_enable_n(o_high_byte_enable_n),
    .o_enables_oe(o_enables_oe), .o_low_data(o_low_data), .o_low_oe(o_low_oe),
    .o_high_data(o_high_data), .o_high_oe(o_high_oe));
  dsadc_host_model host_i (.i_clock(i_clock), .i_status(o_status), .i_low_data(o_low_data),
    .i_low_oe(o_low_oe), .i_high_data(o_high_data), .i_high_oe(o_high_oe),
    .o_chip_enable_n(host_ce_n), .o_low_byte_enable_n(host_lbe_n),
    .o_high_byte_enable_n(host_hbe_n));
  // Clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Comparator crosses k periods into deintegrate; sign held steady
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    dcnt <= (o_phase == 5'h10) ? dcnt + 1 : 0;
    i_zero_cross <= (o_phase == 5'h10) && (dcnt >= k_cur);
    i_sign <= s_cur;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb_xfer(input bit wr, input logic [11:0] a, input logic [31:0] d);
    int m;
    m = 0;
    @(posedge i_clock);
    apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge i_clock);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clock);
      m++;
    end while (o_pready !== 1'b1 && m < 20);
    rd = o_prdata;
    er = o_pslverr;
    apb <= '0;
  endtask : apb_xfer
  function automatic logic [4:0] pick(input int w);
    case (w)
      0: return {4'h0, o_status};
      1: return o_phase;
      2: return {4'h0, o_chip_enable_n};
      3: return {4'h0, o_low_oe};
      default: return {4'h0, o_enables_oe};
    endcase
  endfunction : pick
  task automatic wait_on(input int w, input logic [4:0] v, input int lim, output int c);
    c = 0;
    while (pick(w) !== v && c < lim) begin
      @(posedge i_clock);
      #1;
      c++;
    end
  endtask : wait_on
  // One conversion against the model, then both bytes read by the host
  task automatic conv(input int k, input bit s, input bit cont);
    int c;
    k_cur = k;
    s_cur = s;
    exp_q.push_back('{over_range: k >= 4096, sign_flag: s, count: 12'hFFF});
    wait_on(0, 5'h01, 9000, c);
    if (cont && prev_t >= 0) chk(cyc - prev_t, 8192);
    prev_t = cyc;
    wait_on(0, 5'h00, 6200, c);
    exp_r = exp_q.pop_front();
    apb_xfer(1'b0, `DSADC_RESULT_OFS, 32'h0);
    chk(rd[13:12], {exp_r.over_range, exp_r.sign_flag});
    if (exp_r.over_range) chk(rd[11:0], 12'hFFF);
    else chk(rd[11:0] >= k && rd[11:0] <= k + 4, 1);
    exp_r.count = rd[11:0];
    host_i.read_byte(1'b0, 1'b1, 4 + $urandom_range(4), b);
    chk(b, {1'b1, exp_r.count[7:0]});
    host_i.read_byte(1'b1, 1'b1, 4, b);
    chk(b, {3'b100, exp_r.over_range, exp_r.sign_flag, exp_r.count[11:8]});
  endtask : conv
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    apb = '0;
    i_send = 1'b1;
    void'($urandom(22));
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    chk(o_enables_oe, 1'b0);
    apb_xfer(1'b0, `DSADC_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb_xfer(1'b0, 12'h00C, 32'h0);
    chk({er, rd[0]}, 2'b10);
    for (int i = 0; i < 4; i++) conv(i == 1 ? 5000 : 1 + $urandom_range(2999), 1'($urandom), 1'b1);
    host_i.read_byte(1'b0, 1'b0, 6, b);
    chk(b[8], 1'b0);
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h0);
    wait_on(1, 5'h01, 3, n);
    chk(o_phase, 5'h01);
    wait_on(1, 5'h02, 2200, n);
    chk({o_phase, n >= 2040}, {5'h02, 1'b1});
    repeat (40) @(posedge i_clock);
    chk({o_phase, o_status}, {5'h02, 1'b0});
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h1);
    wait_on(0, 5'h01, 20, n);
    chk(n, 7);
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h0);
    conv(200, 1'b1, 1'b0);
    wait_on(1, 5'h02, 2200, n);
    chk(o_phase, 5'h02);
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h2);
    wait_on(2, 5'h00, 20, n);
    chk(o_enables_oe, 1'b1);
    chk({o_high_oe, o_high_byte_enable_n, o_high_data},
      {2'b10, exp_r.over_range, exp_r.sign_flag, exp_r.count[11:8]});
    wait_on(3, 5'h01, 20, n);
    chk({o_chip_enable_n, o_low_byte_enable_n, o_low_data}, {2'b00, exp_r.count[7:0]});
    wait_on(3, 5'h00, 20, n);
    repeat (3) @(posedge i_clock);
    chk({o_enables_oe, o_chip_enable_n, o_low_byte_enable_n, o_high_byte_enable_n}, 4'hF);
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h0);
    wait_on(4, 5'h00, 6, n);
    chk(o_enables_oe, 1'b0);
    host_i.read_byte(1'b0, 1'b1, 5, b);
    chk(b, {1'b1, exp_r.count[7:0]});
    // Receiver stalls: the new result must not reach the latches
    i_send <= 1'b0;
    k_cur = 100;
    apb_xfer(1'b1, `DSADC_CTRL_OFS, 32'h3);
    wait_on(0, 5'h01, 20, n);
    wait_on(0, 5'h00, 2300, n);
    apb_xfer(1'b0, `DSADC_RESULT_OFS, 32'h0);
    chk(rd, {18'h00000, exp_r});
    apb_xfer(1'b0, `DSADC_STAT_OFS, 32'h0);
    chk(rd, 32'h2);
    i_send <= 1'b1;
    wait_on(2, 5'h00, 20, n);
    chk({o_high_oe, o_high_byte_enable_n, o_high_data},
      {2'b10, exp_r.over_range, exp_r.sign_flag, exp_r.count[11:8]});
    // Mode held high: the next result goes out by itself
    wait_on(0, 5'h01, 8200, n);
    wait_on(0, 5'h00, 2300, n);
    wait_on(2, 5'h00, 20, n);
    chk({o_high_oe, o_high_data[5:4]}, {2'b10, s_cur});
    final_report();
  end
  // Watchdog: about ten conversion cycles
  initial begin
    repeat (80000) @(posedge i_clock);
    err_total++;
    final_report();
  end
endmodule : dual_slope_adc_sequencer_direct_port_tb_top
